// ==== shared/exception_pkg.sv ====
package exception_pkg;

    // register byte offsets inside the system control space
    localparam logic [11:0] ICS_OFFSET = 12'hd04;
    localparam logic [11:0] IRQ_STATUS_OFFSET = 12'hd40;
    localparam logic [11:0] IRQ_MASK_OFFSET = 12'hd44;

    // reset values
    localparam logic [31:0] ICS_RESET = 32'h00000000;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // field positions of the interrupt control state word
    localparam int NMI_SET_BIT = 31;
    localparam int SVC_SET_BIT = 28;
    localparam int SVC_CLR_BIT = 27;
    localparam int TICK_SET_BIT = 26;
    localparam int TICK_CLR_BIT = 25;
    localparam int PREEMPT_BIT = 23;
    localparam int EXT_PEND_BIT = 22;
    localparam int PVEC_LSB = 12;
    localparam int AVEC_LSB = 0;
    localparam int VEC_WIDTH = 9;

    // exception numbers
    localparam logic [8:0] NO_VECTOR = 9'h000;
    localparam logic [8:0] NMI_VECTOR = 9'h002;
    localparam logic [8:0] SVC_VECTOR = 9'h00e;
    localparam logic [8:0] TICK_VECTOR = 9'h00f;
    localparam logic [8:0] EXT_VECTOR_BASE = 9'h010;

    // event bits of the interrupt status and mask registers
    localparam int EV_NMI = 0;
    localparam int EV_SVC = 1;
    localparam int EV_TICK = 2;
    localparam int EVENT_COUNT = 3;

    // axi4-lite response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : exception_pkg

// ==== hdl/pending_flag.sv ====
`timescale 1ns/10ps
module pending_flag
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // requests
    input wire logic set,
    input wire logic clear,
    // state
    output logic flag_reg
);

    typedef struct packed
    {
        logic flag;
    } flag_state_type;

    flag_state_type st_reg;
    flag_state_type st_next;

    // a set in the same cycle as a clear wins
    always_comb
    begin
        st_next = st_reg;
        st_next.flag = (st_reg.flag & ~clear) | set;
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign flag_reg = st_reg.flag;

endmodule : pending_flag

// ==== hdl/lowest_pick.sv ====
`timescale 1ns/10ps
module lowest_pick
#(
    parameter int WIDTH = 32,
    parameter int INDEX_WIDTH = 5
)
(
    // request lines
    input wire logic [WIDTH-1:0] req,
    // result
    output logic found,
    output logic [INDEX_WIDTH-1:0] index
);

    // lowest set request wins, scanned from the top down
    always_comb
    begin
        found = 1'b0;
        index = '0;
        for (int i = WIDTH - 1; i >= 0; i--)
        begin
            if (req[i])
            begin
                found = 1'b1;
                index = INDEX_WIDTH'(i);
            end
        end
    end

endmodule : lowest_pick

// ==== hdl/exception_pending_control.sv ====
// Functional notes
// - write one sets nonmaskable pending, zero ignored
// - bit 31 reads nonmaskable pending state
// - nonmaskable pending requests entry immediately; exception_request here rises one cycle after nmi_pending
// - nonmaskable handler entry clears its pending
// - bit 28 write one pends service, reads state
// - bit 28 reads zero when not pending
// - only software write pends service exception
// - bit 27 write one clears service pending
// - bit 27 write-only, reads zero
// - control word at 0xd04, resets zero
// - bits 26/25 set and clear tick pending
// - bits 20:12 give highest pending vector
// - bits 8:0 give active vector number
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module exception_pending_control
    import exception_pkg::*;
#(
    parameter int ADDR_WIDTH = 12,
    parameter int NUM_IRQ = 32
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_WIDTH-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [ADDR_WIDTH-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // hardware exception sources
    input wire logic nmi_request,
    input wire logic tick_request,
    input wire logic [NUM_IRQ-1:0] external_irq,
    // core handshake
    input wire logic handler_entry,
    input wire logic [8:0] entry_vector,
    input wire logic handler_exit,
    // state towards the core
    output logic exception_request,
    output logic [8:0] pending_vector_number,
    output logic [8:0] active_vector_number,
    output logic external_request_pending,
    output logic nmi_pending,
    output logic service_pending,
    output logic tick_pending,
    // interrupt
    output logic irq
);

    // index width of the external request picker, at least one bit
    localparam int IRQ_INDEX_WIDTH = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

    typedef struct packed
    {
        logic aw_full;
        logic [11:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [EVENT_COUNT-1:0] irq_status;
        logic [EVENT_COUNT-1:0] irq_mask;
        logic irq;
        logic exc_request;
        logic [8:0] pending_vec;
        logic [8:0] active_vec;
        logic ext_pending;
    } ctrl_state_type;

    ctrl_state_type st_reg;
    ctrl_state_type st_next;

    logic nmi_flag;
    logic svc_flag;
    logic tick_flag;
    logic ext_found;
    logic [IRQ_INDEX_WIDTH-1:0] ext_index;

    logic do_write;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic wr_ics;
    logic wr_status;
    logic wr_mask;
    logic nmi_set;
    logic svc_set;
    logic svc_clr;
    logic tick_set;
    logic tick_clr;
    logic nmi_enter;
    logic svc_enter;
    logic tick_enter;
    logic [EVENT_COUNT-1:0] events;
    logic [31:0] ics_word;
    logic [8:0] pick_vec;

    // write decode: a write executes once address and data are both held
    always_comb
    begin
        do_write = st_reg.aw_full & st_reg.w_full & ~st_reg.bvalid;
        for (int b = 0; b < 4; b++)
        begin
            wmask[b*8 +: 8] = {8{st_reg.w_strb[b]}};
        end
        wbits = st_reg.w_data & wmask;
        wr_ics = do_write & (st_reg.aw_addr[11:2] == ICS_OFFSET[11:2]);
        wr_status = do_write & (st_reg.aw_addr[11:2] == IRQ_STATUS_OFFSET[11:2]);
        wr_mask = do_write & (st_reg.aw_addr[11:2] == IRQ_MASK_OFFSET[11:2]);
    end

    // set and clear strobes of the pending flags
    always_comb
    begin
        nmi_set = (wr_ics & wbits[NMI_SET_BIT]) | nmi_request;
        svc_set = wr_ics & wbits[SVC_SET_BIT];
        svc_clr = wr_ics & wbits[SVC_CLR_BIT];
        tick_set = (wr_ics & wbits[TICK_SET_BIT]) | tick_request;
        tick_clr = wr_ics & wbits[TICK_CLR_BIT];
        nmi_enter = handler_entry & (entry_vector == NMI_VECTOR);
        svc_enter = handler_entry & (entry_vector == SVC_VECTOR);
        tick_enter = handler_entry & (entry_vector == TICK_VECTOR);
        events = '0;
        events[EV_NMI] = nmi_set;
        events[EV_SVC] = svc_set;
        events[EV_TICK] = tick_set;
    end

    // nonmaskable pending flag, entry clears, new request wins
    pending_flag nmi_flag_inst
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(nmi_set),
        .clear(nmi_enter),
        .flag_reg(nmi_flag)
    );

    // service pending flag, only a software write sets it
    pending_flag svc_flag_inst
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(svc_set),
        .clear(svc_clr | svc_enter),
        .flag_reg(svc_flag)
    );

    // periodic tick pending flag
    pending_flag tick_flag_inst
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(tick_set),
        .clear(tick_clr | tick_enter),
        .flag_reg(tick_flag)
    );

    // lowest numbered external request
    lowest_pick
    #(
        .WIDTH(NUM_IRQ),
        .INDEX_WIDTH(IRQ_INDEX_WIDTH)
    )
    ext_pick_inst
    (
        .req(external_irq),
        .found(ext_found),
        .index(ext_index)
    );

    // fixed priority: nonmaskable, external, tick, service
    // external lines are read straight from the pins, so a new request
    // reaches the pending vector one edge after it appears
    always_comb
    begin
        if (nmi_flag)
            pick_vec = NMI_VECTOR;
        else if (ext_found)
            pick_vec = EXT_VECTOR_BASE + VEC_WIDTH'(ext_index);
        else if (tick_flag)
            pick_vec = TICK_VECTOR;
        else if (svc_flag)
            pick_vec = SVC_VECTOR;
        else
            pick_vec = NO_VECTOR;
    end

    // read image of the control word, unlisted bits stay zero
    always_comb
    begin
        ics_word = ICS_RESET;
        ics_word[NMI_SET_BIT] = nmi_flag;
        ics_word[SVC_SET_BIT] = svc_flag;
        ics_word[TICK_SET_BIT] = tick_flag;
        ics_word[PREEMPT_BIT] = 1'b0;
        ics_word[EXT_PEND_BIT] = st_reg.ext_pending;
        ics_word[PVEC_LSB +: VEC_WIDTH] = st_reg.pending_vec;
        ics_word[AVEC_LSB +: VEC_WIDTH] = st_reg.active_vec;
    end

    // bus handshakes, register writes and core-facing state
    always_comb
    begin
        st_next = st_reg;

        // write address and data are taken independently
        if (awvalid && st_reg.awready)
        begin
            st_next.aw_full = 1'b1;
            st_next.aw_addr = awaddr[11:0];
        end
        if (wvalid && st_reg.wready)
        begin
            st_next.w_full = 1'b1;
            st_next.w_data = wdata;
            st_next.w_strb = wstrb;
        end

        // write execution and response
        if (do_write)
        begin
            st_next.aw_full = 1'b0;
            st_next.w_full = 1'b0;
            st_next.bvalid = 1'b1;
            if (wr_ics || wr_status || wr_mask)
                st_next.bresp = RESP_OKAY;
            else
                st_next.bresp = RESP_SLVERR;
        end
        else if (st_reg.bvalid && bready)
        begin
            st_next.bvalid = 1'b0;
        end
        st_next.awready = ~st_next.aw_full & ~st_next.bvalid;
        st_next.wready = ~st_next.w_full & ~st_next.bvalid;

        // interrupt mask and sticky status, set wins over write-one clear
        if (wr_mask)
            st_next.irq_mask = wbits[EVENT_COUNT-1:0];
        if (wr_status)
            st_next.irq_status = st_reg.irq_status & ~wbits[EVENT_COUNT-1:0];
        st_next.irq_status = st_next.irq_status | events;
        st_next.irq = |(st_next.irq_status & st_next.irq_mask);

        // read channel, one outstanding read
        if (arvalid && st_reg.arready)
        begin
            st_next.rvalid = 1'b1;
            st_next.rresp = RESP_OKAY;
            if (araddr[11:2] == ICS_OFFSET[11:2])
                st_next.rdata = ics_word;
            else if (araddr[11:2] == IRQ_STATUS_OFFSET[11:2])
                st_next.rdata = {29'h0, st_reg.irq_status};
            else if (araddr[11:2] == IRQ_MASK_OFFSET[11:2])
                st_next.rdata = {29'h0, st_reg.irq_mask};
            else
            begin
                st_next.rdata = 32'h00000000;
                st_next.rresp = RESP_SLVERR;
            end
        end
        else if (st_reg.rvalid && rready)
        begin
            st_next.rvalid = 1'b0;
        end
        // arready stays low while an answer stands: only one read is ever open
        st_next.arready = ~st_next.rvalid & ~(arvalid & st_reg.arready);

        // active exception tracks entry and return to thread mode
        if (handler_entry)
            st_next.active_vec = entry_vector;
        else if (handler_exit)
            st_next.active_vec = NO_VECTOR;

        // core-facing pending summary
        // request and vector are registered together so they always agree
        st_next.pending_vec = pick_vec;
        st_next.exc_request = (pick_vec != NO_VECTOR);
        st_next.ext_pending = |external_irq;
    end

    // state register, all zero after reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.irq_mask <= IRQ_MASK_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign awready = st_reg.awready;
    assign wready = st_reg.wready;
    assign bvalid = st_reg.bvalid;
    assign bresp = st_reg.bresp;
    assign arready = st_reg.arready;
    assign rvalid = st_reg.rvalid;
    assign rresp = st_reg.rresp;
    assign rdata = st_reg.rdata;
    assign irq = st_reg.irq;
    assign exception_request = st_reg.exc_request;
    assign pending_vector_number = st_reg.pending_vec;
    assign active_vector_number = st_reg.active_vec;
    assign external_request_pending = st_reg.ext_pending;
    assign nmi_pending = nmi_flag;
    assign service_pending = svc_flag;
    assign tick_pending = tick_flag;

endmodule : exception_pending_control

// ==== tb/exception_pending_control_sva.sv ====
`timescale 1ns/10ps
module pending_control_sva
    import exception_pkg::*;
#(
    parameter int NUM_IRQ = 32
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus answers
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    // core side
    input wire logic nmi_request,
    input wire logic tick_request,
    input wire logic [NUM_IRQ-1:0] external_irq,
    input wire logic handler_entry,
    input wire logic [8:0] entry_vector,
    input wire logic handler_exit,
    input wire logic exception_request,
    input wire logic [8:0] pending_vector_number,
    input wire logic [8:0] active_vector_number,
    input wire logic external_request_pending,
    input wire logic nmi_pending,
    input wire logic service_pending,
    input wire logic tick_pending
);
    default clocking main_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // nonmaskable handler entry without a fresh request
    sequence nmi_entry_s;
        handler_entry && entry_vector == NMI_VECTOR && !nmi_request;
    endsequence

    // nothing pending for two cycles, lag of the sources included
    sequence quiet_s;
        (!nmi_pending && !service_pending && !tick_pending && external_irq == '0 && !external_request_pending) [*2];
    endsequence

    // flag behaviour
    nmi_set_a: assert property (nmi_request |=> nmi_pending) else $error("nmi request lost");
    nmi_entry_a: assert property (nmi_entry_s |=> !nmi_pending || $rose(bvalid)) else $error("nmi kept");
    nmi_urgent_a: assert property (nmi_pending |-> ##[0:2] exception_request) else $error("no request");
    svc_source_a: assert property ($rose(service_pending) |-> $rose(bvalid)) else $error("service set");
    tick_set_a: assert property (tick_request |=> tick_pending) else $error("tick request lost");

    // vector fields
    pvec_nmi_a: assert property (nmi_pending |=> pending_vector_number == NMI_VECTOR) else $error("pvec");
    pvec_idle_a: assert property (quiet_s |=> pending_vector_number == NO_VECTOR) else $error("pvec idle");
    act_entry_a: assert property (handler_entry |=> active_vector_number == $past(entry_vector)) else $error("act");
    act_exit_a: assert property (handler_exit && !handler_entry |=> active_vector_number == NO_VECTOR) else $error("exit");

    // bus answers
    reserved_zero_a: assert property (rvalid |-> (rdata & 32'h6ba00e00) == '0) else $error("reserved set");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
endmodule : pending_control_sva

bind exception_pending_control pending_control_sva #(.NUM_IRQ(NUM_IRQ)) sva
(
    .aclk(aclk),
    .aresetn(aresetn),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .rdata(rdata),
    .rvalid(rvalid),
    .nmi_request(nmi_request),
    .tick_request(tick_request),
    .external_irq(external_irq),
    .handler_entry(handler_entry),
    .entry_vector(entry_vector),
    .handler_exit(handler_exit),
    .exception_request(exception_request),
    .pending_vector_number(pending_vector_number),
    .active_vector_number(active_vector_number),
    .external_request_pending(external_request_pending),
    .nmi_pending(nmi_pending),
    .service_pending(service_pending),
    .tick_pending(tick_pending)
);

// ==== tb/exception_pending_control_test.sv ====
`timescale 1ns/10ps
module exception_pending_control_test
    import exception_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] awaddr = '0;
    logic [11:0] araddr = '0;
    logic [2:0] awprot = '0;
    logic [2:0] arprot = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic nmi_request = 1'b0, tick_request = 1'b0, handler_entry = 1'b0, handler_exit = 1'b0;
    logic [8:0] entry_vector = '0;
    logic [31:0] external_irq = '0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic exception_request, external_request_pending, nmi_pending, service_pending, tick_pending;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd_data, d, h;
    logic [8:0] pending_vector_number, active_vector_number, v;
    logic [1:0] resp;
    logic [8:0] vec_tab [3] = '{NMI_VECTOR, SVC_VECTOR, TICK_VECTOR};
    int nmi, svc, tick, act, st, msk, k, bad_count, n_checks;
    int ext = -1;

    exception_pending_control dut
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awprot(awprot),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arprot(arprot),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .nmi_request(nmi_request),
        .tick_request(tick_request),
        .external_irq(external_irq),
        .handler_entry(handler_entry),
        .entry_vector(entry_vector),
        .handler_exit(handler_exit),
        .exception_request(exception_request),
        .pending_vector_number(pending_vector_number),
        .active_vector_number(active_vector_number),
        .external_request_pending(external_request_pending),
        .nmi_pending(nmi_pending),
        .service_pending(service_pending),
        .tick_pending(tick_pending),
        .irq(irq)
    );

    // free running clock
    initial
    begin
        forever #2 aclk = ~aclk;
    end

    // expected control word from the model state
    function automatic logic [31:0] control_word_exp();
        int pv;
        pv = nmi ? 2 : ext >= 0 ? 16 + ext : tick ? 15 : svc ? 14 : 0;
        return {nmi[0], 2'b0, svc[0], 1'b0, tick[0], 3'b0, ext >= 0, 1'b0, pv[8:0], 3'b0, act[8:0]};
    endfunction : control_word_exp

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
        end
    endtask : chk

    // one axi4-lite write, address and data offered together
    // bready is raised only once the answer stands, so the answer must wait for it
    task automatic wr(input logic [11:0] a, input logic [31:0] dv);
        awaddr <= a;
        wdata <= dv;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        bready <= 1'b1;
        @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    // one axi4-lite read
    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        rd_data = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // hang guard
    initial
    begin
        #100000;
        bad_count++;
        tally_and_finish();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'hd2b025d7));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ICS_OFFSET);
        chk("reset word", rd_data, ICS_RESET);
        rd(IRQ_MASK_OFFSET);
        chk("reset mask", rd_data, 32'(IRQ_MASK_RESET));
        wr(12'h100, 32'hffffffff);
        chk("unmapped write", 32'(resp), 32'(RESP_SLVERR));
        rd(12'h100);
        chk("unmapped read", rd_data, '0);
        chk("unmapped resp", 32'(resp), 32'(RESP_SLVERR));
        // random software writes mixed with core events
        repeat (40)
        begin
            d = $urandom;
            h = $urandom;
            v = vec_tab[h[5:4] % 3];
            wr(ICS_OFFSET, d);
            chk("word resp", 32'(resp), 32'(RESP_OKAY));
            nmi |= d[31];
            svc = d[28] ? 1 : d[27] ? 0 : svc;
            tick = d[26] ? 1 : d[25] ? 0 : tick;
            st |= {d[26], d[28], d[31]};
            msk = h[14:12];
            wr(IRQ_MASK_OFFSET, 32'(h[14:12]));
            handler_entry <= h[0];
            entry_vector <= v;
            nmi_request <= h[1];
            tick_request <= h[2];
            handler_exit <= h[3];
            @(posedge aclk);
            handler_entry <= 1'b0;
            nmi_request <= 1'b0;
            tick_request <= 1'b0;
            handler_exit <= 1'b0;
            nmi = (h[0] && v == NMI_VECTOR) ? h[1] : nmi | h[1];
            svc = (h[0] && v == SVC_VECTOR) ? 0 : svc;
            tick = (h[0] && v == TICK_VECTOR) ? h[2] : tick | h[2];
            act = h[0] ? v : h[3] ? 0 : act;
            st |= {h[2], 1'b0, h[1]};
            repeat (3) @(posedge aclk);
            rd(ICS_OFFSET);
            chk("control word", rd_data, control_word_exp());
            rd(IRQ_STATUS_OFFSET);
            chk("event status", rd_data, 32'(st));
            chk("irq", 32'(irq), 32'(|(st & msk)));
            wr(IRQ_STATUS_OFFSET, 32'(h[10:8]));
            st &= ~h[10:8];
        end
        // software pends the service exception, then clears it the documented way
        wr(ICS_OFFSET, 32'h1 << SVC_SET_BIT);
        svc = 1;
        st |= 2;
        wr(ICS_OFFSET, 32'h1 << SVC_CLR_BIT);
        svc = 0;
        // one external request against the fixed priority order
        k = $urandom % 32;
        ext = k;
        external_irq <= 32'h1 << k;
        repeat (3) @(posedge aclk);
        rd(ICS_OFFSET);
        chk("external word", rd_data, control_word_exp());
        chk("ext pending", 32'(external_request_pending), 32'h1);
        tally_and_finish();
    end
endmodule : exception_pending_control_test
